// ==== include/ppc_pkg.sv ====
package ppc_pkg;

    // register byte offsets
    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  STAT_OFS      = 8'h04;

    // control register field positions
    localparam int          ENABLE_BIT    = 15;
    localparam int          STOP_IDLE_BIT = 13;
    localparam int          MUX_LSB       = 11;
    localparam int          TTL_BIT       = 10;
    localparam int          WREN_BIT      = 9;
    localparam int          RDEN_BIT      = 8;
    localparam int          CS_FUNC_LSB   = 6;
    localparam int          LATCH_POL_BIT = 5;
    localparam int          CSPOL_BIT     = 3;
    localparam int          WRPOL_BIT     = 1;
    localparam int          RDPOL_BIT     = 0;

    // status register field positions
    localparam int          BUSY_BIT      = 0;
    localparam int          HALT_BIT      = 1;

    // writable bits of the control word and its reset value
    localparam logic [31:0] CTRL_WMASK    = 32'h0000_BFEB;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    // address/data multiplexing schemes
    localparam logic [1:0]  MUX_SEPARATE  = 2'h0;
    localparam logic [1:0]  MUX_LOW_UPPER = 2'h1;
    localparam logic [1:0]  MUX_FULL16    = 2'h2;
    localparam logic [1:0]  MUX_LOW_ONLY  = 2'h3;

    // chip-select function code that makes the pin a chip select
    localparam logic [1:0]  CS_FUNC_SEL   = 2'h2;

    // access sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ALH  = 5'b00010,
        ST_ALL  = 5'b00100,
        ST_DATA = 5'b01000,
        ST_END  = 5'b10000
    } ppc_state_t;

endpackage

// ==== core/ppc_core.sv ====
// Design decisions made here: the plain strobed port and the register addresses.
module ppc_core (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        device_idle,
    input  wire logic        acc_req,
    input  wire logic        acc_write,
    input  wire logic [15:0] acc_addr,
    input  wire logic [7:0]  acc_wdata,
    output logic             acc_ready,
    output logic             acc_done,
    output logic      [7:0]  acc_rdata,
    input  wire logic [7:0]  port_data_pins_in,
    output logic      [7:0]  port_data_pins_out,
    output logic             port_data_pins_oe,
    output logic      [15:0] port_address_pins,
    output logic             chip_select_pin,
    output logic             address_latch_low_strobe,
    output logic             address_latch_high_strobe,
    output logic             write_strobe_pin,
    output logic             write_strobe_pin_oe,
    output logic             read_strobe_pin,
    output logic             read_strobe_pin_oe,
    output logic             input_buffer_type_select
);

    logic [31:0]         ctrl_reg;
    ppc_pkg::ppc_state_t state_reg;
    ppc_pkg::ppc_state_t state_next;
    logic                wr_reg;
    logic [15:0]         addr_reg;
    logic [7:0]          wdata_reg;
    logic                enabled;
    logic                halted;
    logic                run;
    logic [1:0]          mux_sel;
    logic [1:0]          cs_func;
    logic                lat_pol;
    logic                in_access;
    logic                latch_lo_act;
    logic                latch_hi_act;
    logic                strobe_act;
    logic [31:0]         stat_word;

    // field decode of the control word
    assign enabled  = ctrl_reg[ppc_pkg::ENABLE_BIT];
    assign mux_sel  = ctrl_reg[ppc_pkg::MUX_LSB +: 2];
    assign cs_func  = ctrl_reg[ppc_pkg::CS_FUNC_LSB +: 2];
    assign lat_pol  = ctrl_reg[ppc_pkg::LATCH_POL_BIT];

    assign halted   = ctrl_reg[ppc_pkg::STOP_IDLE_BIT] & device_idle;
    // only an enabled, running port sequences
    assign run      = enabled & ~halted;

    // buffer type straight from the control bit
    assign input_buffer_type_select = ctrl_reg[ppc_pkg::TTL_BIT];

    // control register write; unimplemented bits never store
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg <= ppc_pkg::CTRL_RESET;
        end else if (reg_wr && reg_addr == ppc_pkg::CTRL_OFS) begin
            ctrl_reg <= reg_wdata & ppc_pkg::CTRL_WMASK;
        end
    end

    // status word shows sequencer busy and the halt from stop bit and device idle
    always_comb begin
        stat_word                     = 32'h0000_0000;
        stat_word[ppc_pkg::BUSY_BIT]  = (state_reg != ppc_pkg::ST_IDLE);
        stat_word[ppc_pkg::HALT_BIT]  = halted;
    end

    // read data valid only in the cycle after the read strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == ppc_pkg::CTRL_OFS) begin
                reg_rdata <= ctrl_reg;
            end else if (reg_addr == ppc_pkg::STAT_OFS) begin
                reg_rdata <= stat_word;
            end else begin
                reg_rdata <= 32'h0000_0000; // unmapped reads as zero
            end
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // new request accepted only when idle and running
    assign acc_ready = run & (state_reg == ppc_pkg::ST_IDLE);

    // sequencer next state; a halt freezes it where it stands
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ppc_pkg::ST_IDLE: begin
                if (acc_req && acc_ready) begin
                    // separate pins go straight to data
                    if (mux_sel == ppc_pkg::MUX_SEPARATE) begin
                        state_next = ppc_pkg::ST_DATA;
                    // full sixteen bits need the high phase first
                    end else if (mux_sel == ppc_pkg::MUX_FULL16) begin
                        state_next = ppc_pkg::ST_ALH;
                    end else begin
                        state_next = ppc_pkg::ST_ALL;
                    end
                end
            end
            ppc_pkg::ST_ALH: begin
                if (run) begin
                    state_next = ppc_pkg::ST_ALL;
                end
            end
            ppc_pkg::ST_ALL: begin
                if (run) begin
                    state_next = ppc_pkg::ST_DATA;
                end
            end
            ppc_pkg::ST_DATA: begin
                if (run) begin
                    state_next = ppc_pkg::ST_END;
                end
            end
            ppc_pkg::ST_END: begin
                if (run) begin
                    state_next = ppc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = ppc_pkg::ST_IDLE;
            end
        endcase
        // disabling aborts any access in flight
        if (!enabled) begin
            state_next = ppc_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= ppc_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // request capture; held steady for the whole access
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_reg    <= 1'b0;
            addr_reg  <= 16'h0000;
            wdata_reg <= 8'h00;
        end else if (acc_req && acc_ready) begin
            wr_reg    <= acc_write;
            addr_reg  <= acc_addr;
            wdata_reg <= acc_wdata;
        end
    end

    // read data caught at the end of the strobe phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_rdata <= 8'h00;
        end else if (state_reg == ppc_pkg::ST_DATA && run && !wr_reg) begin
            acc_rdata <= port_data_pins_in;
        end
    end

    // completion pulse on leaving the end phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_done <= 1'b0;
        end else begin
            acc_done <= (state_reg == ppc_pkg::ST_END) && run;
        end
    end

    // phase decode, all gated by enable
    // nothing active while disabled
    assign in_access    = enabled & (state_reg != ppc_pkg::ST_IDLE);
    assign latch_hi_act = enabled & (state_reg == ppc_pkg::ST_ALH);
    assign latch_lo_act = enabled & (state_reg == ppc_pkg::ST_ALL);
    assign strobe_act   = enabled & (state_reg == ppc_pkg::ST_DATA);

    // data pins carry address bytes in latch phases, data on writes
    always_comb begin
        port_data_pins_out = 8'h00;
        port_data_pins_oe  = 1'b0;
        if (latch_hi_act) begin
            port_data_pins_out = addr_reg[15:8];
            port_data_pins_oe  = 1'b1;
        end else if (latch_lo_act) begin
            port_data_pins_out = addr_reg[7:0];
            port_data_pins_oe  = 1'b1;
        end else if (strobe_act && wr_reg) begin
            port_data_pins_out = wdata_reg;
            port_data_pins_oe  = 1'b1;
        end
    end

    // address pins by scheme; zero outside an access
    always_comb begin
        port_address_pins = 16'h0000;
        if (in_access) begin
            case (mux_sel)
                ppc_pkg::MUX_SEPARATE: begin
                    // whole address on its own pins
                    port_address_pins = addr_reg;
                end
                ppc_pkg::MUX_LOW_UPPER: begin
                    // upper bits on 10:8 and 14
                    port_address_pins[10:8] = addr_reg[10:8];
                    port_address_pins[14]   = addr_reg[14];
                end
                default: begin
                    // upper byte unused in low-only and full modes
                    port_address_pins = 16'h0000;
                end
            endcase
        end
    end

    // chip-select pin: select or address bit 14
    always_comb begin
        chip_select_pin = 1'b0;
        // select function only for code 10
        if (cs_func == ppc_pkg::CS_FUNC_SEL) begin
            // active level equals the polarity bit; low while disabled
            chip_select_pin = enabled & (in_access ~^ ctrl_reg[ppc_pkg::CSPOL_BIT]);
        // as an address line the polarity bit has no say
        end else if (in_access && mux_sel != ppc_pkg::MUX_FULL16
                     && mux_sel != ppc_pkg::MUX_LOW_ONLY) begin
            chip_select_pin = addr_reg[14];
        end
    end

    // latch strobes; in separate mode those pins are address bits 0 and 1
    always_comb begin
        if (!enabled) begin
            address_latch_low_strobe  = 1'b0;
            address_latch_high_strobe = 1'b0;
        // polarity ignored while the pins carry address
        end else if (mux_sel == ppc_pkg::MUX_SEPARATE) begin
            address_latch_low_strobe  = in_access & addr_reg[0];
            address_latch_high_strobe = in_access & addr_reg[1];
        end else begin
            address_latch_low_strobe  = ~(latch_lo_act ^ lat_pol);
            address_latch_high_strobe = ~(latch_hi_act ^ lat_pol);
        end
    end

    // read and write strobes with their own polarity bits
    always_comb begin
        // write-strobe pin driven only when enabled
        write_strobe_pin_oe = enabled & ctrl_reg[ppc_pkg::WREN_BIT];
        // read-strobe pin driven only when enabled
        read_strobe_pin_oe  = enabled & ctrl_reg[ppc_pkg::RDEN_BIT];
        write_strobe_pin    = 1'b0;
        read_strobe_pin     = 1'b0;
        if (write_strobe_pin_oe) begin
            write_strobe_pin = ~((strobe_act & wr_reg) ^ ctrl_reg[ppc_pkg::WRPOL_BIT]);
        end
        if (read_strobe_pin_oe) begin
            read_strobe_pin  = ~((strobe_act & ~wr_reg) ^ ctrl_reg[ppc_pkg::RDPOL_BIT]);
        end
    end

endmodule // ppc_core

// ==== sim/ppc_core_monitor.sv ====
module ppc_core_monitor (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        device_idle,
    input wire logic        acc_req,
    input wire logic [15:0] acc_addr,
    input wire logic        acc_ready,
    input wire logic        acc_done,
    input wire logic [7:0]  port_data_pins_out,
    input wire logic        port_data_pins_oe,
    input wire logic [15:0] port_address_pins,
    input wire logic        chip_select_pin,
    input wire logic        address_latch_low_strobe,
    input wire logic        address_latch_high_strobe,
    input wire logic        write_strobe_pin_oe,
    input wire logic        read_strobe_pin_oe,
    input wire logic        input_buffer_type_select
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] ctrl_reg;
    logic        take;
    logic [1:0]  mux;
    // shadow of the control word, masked like the real one
    always_ff @(posedge clk_sys) begin
        if (rst)
            ctrl_reg <= 32'h0000_0000;
        else if (reg_wr && reg_addr == ppc_pkg::CTRL_OFS)
            ctrl_reg <= reg_wdata & ppc_pkg::CTRL_WMASK;
    end
    assign take = acc_req && acc_ready;
    assign mux  = ctrl_reg[12:11];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // one settled cycle after disabling, since an abort lands at that edge
    a_off_no_access: assert property (!ctrl_reg[15] && !$past(ctrl_reg[15]) |->
        !acc_ready && !port_data_pins_oe && port_address_pins == 16'h0000)
        else $error("port active while disabled");
    a_idle_halts: assert property (ctrl_reg[13] && device_idle |-> !acc_ready)
        else $error("port runs in idle with stop set");
    a_buf_type: assert property (input_buffer_type_select == ctrl_reg[10])
        else $error("buffer type differs from control");
    a_wr_pin_off: assert property (!ctrl_reg[9] |-> !write_strobe_pin_oe)
        else $error("write strobe driven while off");
    a_rd_pin_off: assert property (!ctrl_reg[8] |-> !read_strobe_pin_oe)
        else $error("read strobe driven while off");
    a_sep_cycle: assert property (take && mux == 2'h0 |=>
        port_address_pins[13:0] == $past(acc_addr[13:0]) && !acc_done ##1 !acc_done ##1 acc_done)
        else $error("separate access wrong");
    a_low_cycle: assert property (take && mux[0] |=> !acc_done [*3] ##1 acc_done)
        else $error("low byte access length wrong");
    a_full_pair: assert property (take && mux == 2'h2 |=>
        port_data_pins_oe && port_data_pins_out == $past(acc_addr[15:8])
        && address_latch_high_strobe == ctrl_reg[5] ##1 port_data_pins_out == $past(acc_addr[7:0], 2)
        && address_latch_low_strobe == ctrl_reg[5] ##3 acc_done)
        else $error("full address phases wrong");
    a_low_only: assert property (take && mux == 2'h3 |=>
        port_data_pins_out == $past(acc_addr[7:0]) && port_address_pins[15:8] == 8'h00)
        else $error("upper address leaked");
    a_upper_pins: assert property (take && mux == 2'h1 |=>
        port_address_pins[10:8] == $past(acc_addr[10:8]))
        else $error("upper address pins wrong");
    a_chip_sel: assert property (take && mux == 2'h2 && ctrl_reg[7:6] == 2'h2 |=>
        chip_select_pin == ctrl_reg[3])
        else $error("chip select level wrong");
endmodule // ppc_core_monitor

bind ppc_core ppc_core_monitor i_ppc_core_monitor (
    .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .device_idle, .acc_req, .acc_addr,
    .acc_ready, .acc_done, .port_data_pins_out, .port_data_pins_oe, .port_address_pins,
    .chip_select_pin, .address_latch_low_strobe, .address_latch_high_strobe,
    .write_strobe_pin_oe, .read_strobe_pin_oe, .input_buffer_type_select
);

// ==== sim/ppc_ext_mem.sv ====
module ppc_ext_mem (
    input wire logic        clk_sys,
    input wire logic        sep_mode,
    input wire logic        lat_pol,
    input wire logic        rd_pol,
    input wire logic        wr_pol,
    input wire logic [7:0]  data_out,
    input wire logic        data_oe,
    input wire logic [15:0] addr_pins,
    input wire logic        latch_low,
    input wire logic        rd_pin,
    input wire logic        rd_oe,
    input wire logic        wr_pin,
    input wire logic        wr_oe,
    output logic     [7:0]  data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] lat_reg, last_reg, a;
    assign a = sep_mode ? addr_pins[7:0] : lat_reg;
    // latch, store and remember the last bus value
    always_ff @(posedge clk_sys) begin
        if (!sep_mode && data_oe && latch_low == lat_pol)
            lat_reg <= data_out;
        if (wr_oe && wr_pin == wr_pol)
            mem[a] <= data_out;
        last_reg <= data_in;
    end
    // released bus shows inverted stale data, never a copy
    assign data_in = (rd_oe && rd_pin == rd_pol) ? mem[a] : ~last_reg;
endmodule // ppc_ext_mem

// ==== sim/tb_ppc_core.sv ====
module tb_ppc_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, reg_wr, reg_rd, device_idle, acc_req, acc_write;
    logic        acc_ready, acc_done, pd_oe, cs, all_s, alh_s, wr_p, wr_oe, rd_p, rd_oe, ttl;
    logic        m_sep, m_lpol, m_rdp, m_wrp;
    logic [7:0]  reg_addr, acc_wdata, acc_rdata, pd_in, pd_out;
    logic [15:0] acc_addr, pa;
    logic [31:0] reg_wdata, reg_rdata;
    int          fails, check_count, cyc;
    ppc_core i_ppc_core (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .device_idle, .acc_req, .acc_write, .acc_addr, .acc_wdata, .acc_ready, .acc_done,
        .acc_rdata, .port_data_pins_in(pd_in), .port_data_pins_out(pd_out),
        .port_data_pins_oe(pd_oe), .port_address_pins(pa), .chip_select_pin(cs),
        .address_latch_low_strobe(all_s), .address_latch_high_strobe(alh_s),
        .write_strobe_pin(wr_p), .write_strobe_pin_oe(wr_oe), .read_strobe_pin(rd_p),
        .read_strobe_pin_oe(rd_oe), .input_buffer_type_select(ttl));
    ppc_ext_mem i_ppc_ext_mem (.clk_sys, .sep_mode(m_sep), .lat_pol(m_lpol), .rd_pol(m_rdp),
        .wr_pol(m_wrp), .data_out(pd_out), .data_oe(pd_oe), .addr_pins(pa), .latch_low(all_s),
        .rd_pin(rd_p), .rd_oe(rd_oe), .wr_pin(wr_p), .wr_oe(wr_oe), .data_in(pd_in));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic give_verdict();
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rwr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rrd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // port must be idle and ready on entry
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        acc_req <= 1'b1;
        acc_write <= w;
        acc_addr <= a;
        acc_wdata <= d;
        @(posedge clk_sys);
        acc_req <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (acc_done !== 1'b1 && n < 12);
        chk(acc_done, 1'b1);
    endtask
    // hang guard, well above the expected run length
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        logic [31:0] v, c;
        logic [15:0] a;
        logic [7:0]  d;
        {rst, reg_wr, reg_rd, device_idle, acc_req, acc_write} = 6'h21;
        {reg_addr, acc_wdata, acc_addr, reg_wdata} = '0;
        {m_sep, m_lpol, m_rdp, m_wrp} = 4'h0;
        {cyc, fails, check_count} = '0;
        void'($urandom(25));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rrd(8'h00, v);
        chk(v, 32'h0000_0000);
        rwr(8'h00, 32'hFFFF_FFFF);
        rrd(8'h00, v);
        chk(v, ppc_pkg::CTRL_WMASK);
        chk(ttl, 1'b1);
        rwr(8'h00, 32'h0000_0000);
        // quiet cycle after clearing the enable bit
        @(posedge clk_sys);
        rrd(8'h08, v);
        chk(v, 32'h0000_0000);
        chk({acc_ready, pd_oe, pa}, 32'h0);
        rwr(8'h00, 32'h0000_A000);
        device_idle <= 1'b1;
        #1 chk(acc_ready, 1'b0);
        rrd(ppc_pkg::STAT_OFS, v);
        chk(v, 32'h0000_0001 << ppc_pkg::HALT_BIT);
        rwr(8'h00, 32'h0000_8000);
        #1 chk(acc_ready, 1'b1);
        @(posedge clk_sys);
        device_idle <= 1'b0;
        acc(1'b1, 16'h00FF, 8'hA5);
        // every mux scheme, random pin polarities and chip-select codes
        for (int m = 0; m < 4; m++) begin
            c = 32'h0000_8300 | (m << 11) | ($urandom & 32'h0000_04EB);
            m_sep = (m == 0);
            {m_lpol, m_wrp, m_rdp} = {c[5], c[1], c[0]};
            rwr(8'h00, c);
            repeat (6) begin
                a = 16'($urandom);
                d = 8'($urandom);
                acc(1'b1, a, d);
                acc(1'b0, a, 8'h00);
                chk(acc_rdata, d);
            end
        end
        give_verdict();
    end
endmodule // tb_ppc_core
